//--- ppfm_pkg.sv
// Package for the port pin function multiplexer: widths, reset values, carriers.
// Assumes one 200 MHz clock domain and synchronous pin inputs.
package ppfm_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned P0_W = 2;
  localparam int unsigned P1_W = 8;
  localparam int unsigned P2_W = 4;
  localparam int unsigned P3_W = 4;
  localparam int unsigned P4_W = 2;
  localparam int unsigned P6_W = 2;
  localparam int unsigned P7_W = 2;
  localparam int unsigned P12_W = 3;
  localparam int unsigned NUM_IRQ = 6;
  localparam int unsigned PIN_W = 27;
  // Pin lane positions inside the flat pin vector
  localparam int unsigned P0_LSB = 0;
  localparam int unsigned P1_LSB = 2;
  localparam int unsigned P2_LSB = 10;
  localparam int unsigned P3_LSB = 14;
  localparam int unsigned P4_LSB = 18;
  localparam int unsigned P6_LSB = 20;
  localparam int unsigned P7_LSB = 22;
  localparam int unsigned P12_LSB = 24;
  // Reset values: all inputs, no pull-ups, port 2 analog
  localparam logic [PIN_W-1:0] DIR_RST = 27'h7ffffff;
  localparam logic [PIN_W-1:0] PULL_RST = 27'h0000000;
  localparam logic [P2_W-1:0] P2_ANALOG_RST = 4'hf;
  // Pins that have a pull-up option: ports 0,1,3,4,7 and port12 bit 0
  localparam logic [PIN_W-1:0] PULL_CAP = 27'h1ffc3ff & 27'h7cfc3ff;
  // Open-drain pins (port 6)
  localparam logic [PIN_W-1:0] OD_MASK = 27'h0300000;

  typedef enum logic [1:0] {
    PPFM_EDGE_NONE,
    PPFM_EDGE_RISE,
    PPFM_EDGE_FALL,
    PPFM_EDGE_BOTH
  } ppfm_edge_t;

  // Per-pin pad control as seen by the pad ring
  typedef struct packed {
    logic [PIN_W-1:0] out;
    logic [PIN_W-1:0] oe_n;
    logic [PIN_W-1:0] pull_en;
  } ppfm_pad_t;

  // Peripheral output drive toward the pins
  typedef struct packed {
    logic csu_clock_out;
    logic csu_clock_oe;
    logic csu_data_out;
    logic uart_a_transmit;
    logic uart_b_transmit;
    logic counter_a_out;
    logic counter_b_out;
    logic interval_timer_a_out;
    logic interval_timer_b_out;
    logic twowire_data_low;
    logic twowire_clock_low;
  } ppfm_periph_out_t;

  // Peripheral inputs taken from the pins
  typedef struct packed {
    logic csu_clock_in;
    logic csu_data_in;
    logic uart_a_receive;
    logic uart_b_receive;
    logic counter_a_clock_in;
    logic counter_b_clock_in;
    logic twowire_data_in;
    logic twowire_clock_in;
    logic ext_lowvolt_detect_in;
    logic ext_main_clock_in;
    logic [3:0] debug_in;
    logic [P2_W-1:0] analog_sel;
  } ppfm_periph_in_t;
endpackage : ppfm_pkg

//--- ppfm_edge_det.sv
// Edge detector for the external interrupt inputs, one per pin.
// Assumes pin samples already registered in the CLK domain.
`timescale 1ns/10ps
`default_nettype none
module ppfm_edge_det
  import ppfm_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic ENABLE,
  input wire ppfm_edge_t MODE,
  input wire logic LEVEL,
  output logic REQ
);
  typedef struct packed {
    logic prev;
    logic req;
  } ppfm_ed_state_t;

  ppfm_ed_state_t s_q;
  ppfm_ed_state_t s_d;
  logic rise;
  logic fall;

  assign rise = LEVEL & ~s_q.prev;
  assign fall = ~LEVEL & s_q.prev;

  always_comb begin
    s_d = s_q;
    s_d.prev = LEVEL;
    s_d.req = 1'b0;
    if (ENABLE) begin
      case (MODE)
        PPFM_EDGE_RISE: s_d.req = rise;
        PPFM_EDGE_FALL: s_d.req = fall;
        PPFM_EDGE_BOTH: s_d.req = rise | fall;
        default: s_d.req = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign REQ = s_q.req;

  rising_edge_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && ENABLE && MODE == PPFM_EDGE_RISE && LEVEL && !s_q.prev) |=> REQ)
    else $error("Rising edge request missing");
  no_req_off_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && !ENABLE) |=> !REQ)
    else $error("Request while edge detect disabled");
endmodule : ppfm_edge_det
`default_nettype wire

//--- ppfm_mux.sv
// Port pin function multiplexer: per-pin direction, pull-up and alternate routing.
// Assumes synchronous pin inputs; pad ring resolves oe_n (low = drive) and pull-ups.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - One direction bit per pin selects input or output.
// - Port or alternate function is chosen per pin.
// - Ports 0, 1, 3, 4, 7 have per-pin pull-up enable registers.
// - Port 12 pull-up only on bit 0; other bits have none.
// - Port 2 pins come out of reset in analog mode.
// - Port 2 alternate mode routes to analog channels 0 to 3.
// - External interrupts trigger on rising, falling or both edges.
// - Port 6 pins drive open-drain: pull low or release.
// - Port 6 alternate mode carries two-wire data and clock lines.
// - Serial clock pin bidirectional; data in input only, data out output only.
// - Each UART gets one receive pin and one transmit pin.
// - Port 1 carries counter A clock and output, interval timer outputs.
// - Port 3 carries interrupts 1-4, counter B clock and output, debug.
// - Ports 4 and 7 are plain I/O only.
// - Port 12 carries interrupt 0, low-volt detect, debug, external clock.
// - Debug pins exist only in the debug-capable variant.
// - Reset input is active low.
module ppfm_mux
  import ppfm_pkg::*;
#(
  parameter bit DEBUG_VARIANT = 1'b0
)
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  // Software mode writes: one strobe loads all control words
  input wire logic CFG_WE,
  input wire logic [PIN_W-1:0] CFG_DIR,
  input wire logic [PIN_W-1:0] CFG_PULL,
  input wire logic [PIN_W-1:0] CFG_ALT,
  input wire logic [PIN_W-1:0] CFG_LATCH,
  input wire logic [2*NUM_IRQ-1:0] CFG_EDGE,
  input wire logic FLASH_PROG_MODE_SELECT,
  // Pad side
  input wire logic [PIN_W-1:0] PIN_IN,
  output ppfm_pad_t PAD,
  // Peripheral side
  input wire ppfm_periph_out_t PERIPH_OUT,
  output ppfm_periph_in_t PERIPH_IN,
  output logic [NUM_IRQ-1:0] EXT_IRQ,
  // Software-visible state
  output logic [PIN_W-1:0] PORT_IN,
  output logic [PIN_W-1:0] DIR_STATE,
  output logic [PIN_W-1:0] ALT_STATE,
  output logic FLASH_PROG_REQ
);
  typedef struct packed {
    logic [PIN_W-1:0] dir;
    logic [PIN_W-1:0] pull;
    logic [PIN_W-1:0] alt;
    logic [PIN_W-1:0] latch;
    logic [2*NUM_IRQ-1:0] edge_sel;
    logic [PIN_W-1:0] pin_s;
    ppfm_pad_t pad;
    ppfm_periph_in_t pin;
    logic flash;
  } ppfm_state_t;

  ppfm_state_t s_q;
  ppfm_state_t s_d;
  logic [PIN_W-1:0] per_o;
  logic [PIN_W-1:0] per_oe;
  logic [PIN_W-1:0] per_has_out;
  logic [NUM_IRQ-1:0] irq_pin;
  logic [NUM_IRQ-1:0] irq_en;

  // Lane index for port p bit b
  function automatic int unsigned lane(input int unsigned lsb, input int unsigned b);
    return lsb + b;
  endfunction : lane

  // Peripheral outputs on their lanes
  always_comb begin
    per_o = '0;
    per_oe = '0;
    per_has_out = '0;
    // Input direction hands the pin to the serial clock, output to transmit A
    per_o[lane(P1_LSB, 0)] = s_q.dir[lane(P1_LSB, 0)] ?
      PERIPH_OUT.csu_clock_out : PERIPH_OUT.uart_a_transmit;
    per_oe[lane(P1_LSB, 0)] = PERIPH_OUT.csu_clock_oe | ~s_q.dir[lane(P1_LSB, 0)];
    per_has_out[lane(P1_LSB, 0)] = 1'b1;
    per_o[lane(P1_LSB, 2)] = PERIPH_OUT.csu_data_out;
    per_oe[lane(P1_LSB, 2)] = 1'b1;
    per_has_out[lane(P1_LSB, 2)] = 1'b1;
    per_o[lane(P1_LSB, 3)] = PERIPH_OUT.uart_b_transmit;
    per_oe[lane(P1_LSB, 3)] = 1'b1;
    per_has_out[lane(P1_LSB, 3)] = 1'b1;
    per_o[lane(P1_LSB, 5)] = PERIPH_OUT.interval_timer_a_out;
    per_oe[lane(P1_LSB, 5)] = 1'b1;
    per_has_out[lane(P1_LSB, 5)] = 1'b1;
    per_o[lane(P1_LSB, 6)] = PERIPH_OUT.interval_timer_b_out;
    // Shares its pin with interrupt 5, so only drives when direction is output
    per_oe[lane(P1_LSB, 6)] = ~s_q.dir[lane(P1_LSB, 6)];
    per_has_out[lane(P1_LSB, 6)] = 1'b1;
    // Counter A output only when direction says output, else pin is its clock
    per_o[lane(P1_LSB, 7)] = PERIPH_OUT.counter_a_out;
    per_oe[lane(P1_LSB, 7)] = ~s_q.dir[lane(P1_LSB, 7)];
    per_has_out[lane(P1_LSB, 7)] = 1'b1;
    per_o[lane(P3_LSB, 3)] = PERIPH_OUT.counter_b_out;
    per_oe[lane(P3_LSB, 3)] = ~s_q.dir[lane(P3_LSB, 3)];
    per_has_out[lane(P3_LSB, 3)] = 1'b1;
    // Two-wire lines only ever pull low
    per_o[lane(P6_LSB, 0)] = 1'b0;
    per_oe[lane(P6_LSB, 0)] = PERIPH_OUT.twowire_clock_low;
    per_has_out[lane(P6_LSB, 0)] = 1'b1;
    per_o[lane(P6_LSB, 1)] = 1'b0;
    per_oe[lane(P6_LSB, 1)] = PERIPH_OUT.twowire_data_low;
    per_has_out[lane(P6_LSB, 1)] = 1'b1;
  end

  // Alternate only for pins that have a function; ports 4 and 7 never
  localparam logic [PIN_W-1:0] ALT_CAP = 27'h733fffc;

  always_comb begin
    s_d = s_q;
    if (CFG_WE) begin
      s_d.dir = CFG_DIR;
      s_d.pull = CFG_PULL & PULL_CAP;
      s_d.alt = CFG_ALT & ALT_CAP;
      s_d.latch = CFG_LATCH;
      s_d.edge_sel = CFG_EDGE;
    end
    s_d.pin_s = PIN_IN;
    s_d.flash = FLASH_PROG_MODE_SELECT;
    for (int unsigned i = 0; i < PIN_W; i++) begin
      if (s_q.alt[i] && per_has_out[i]) begin
        s_d.pad.out[i] = per_o[i];
        s_d.pad.oe_n[i] = ~per_oe[i];
      end else if (OD_MASK[i]) begin
        s_d.pad.out[i] = 1'b0;
        s_d.pad.oe_n[i] = s_q.dir[i] | s_q.latch[i];
      end else if (i >= P2_LSB && i < P2_LSB + P2_W && s_q.alt[i]) begin
        s_d.pad.out[i] = 1'b0;
        s_d.pad.oe_n[i] = 1'b1;
      end else begin
        s_d.pad.out[i] = s_q.latch[i];
        s_d.pad.oe_n[i] = s_q.dir[i];
      end
      // No pull-up while direction is output
      s_d.pad.pull_en[i] = s_q.pull[i] & s_q.dir[i];
    end
    s_d.pin.csu_clock_in = s_q.pin_s[lane(P1_LSB, 0)];
    s_d.pin.csu_data_in = s_q.pin_s[lane(P1_LSB, 1)];
    s_d.pin.uart_a_receive = s_q.pin_s[lane(P1_LSB, 1)];
    s_d.pin.uart_b_receive = s_q.pin_s[lane(P1_LSB, 4)];
    s_d.pin.counter_a_clock_in = s_q.pin_s[lane(P1_LSB, 7)];
    s_d.pin.counter_b_clock_in = s_q.pin_s[lane(P3_LSB, 3)];
    s_d.pin.twowire_clock_in = s_q.pin_s[lane(P6_LSB, 0)];
    s_d.pin.twowire_data_in = s_q.pin_s[lane(P6_LSB, 1)];
    s_d.pin.ext_lowvolt_detect_in = s_q.pin_s[lane(P12_LSB, 0)];
    s_d.pin.ext_main_clock_in = s_q.pin_s[lane(P12_LSB, 2)];
    // Debug lanes read zero on the plain variant
    s_d.pin.debug_in = DEBUG_VARIANT ? {s_q.pin_s[lane(P3_LSB, 2)],
      s_q.pin_s[lane(P3_LSB, 1)], s_q.pin_s[lane(P12_LSB, 2)],
      s_q.pin_s[lane(P12_LSB, 1)]} : 4'h0;
    s_d.pin.analog_sel = s_q.alt[P2_LSB +: P2_W];
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '0;
      s_q.dir <= DIR_RST;
      s_q.pull <= PULL_RST;
      s_q.alt <= {{(PIN_W-P2_LSB-P2_W){1'b0}}, P2_ANALOG_RST, {P2_LSB{1'b0}}};
      s_q.pad.oe_n <= DIR_RST;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // Interrupt pins: port12 bit0, port3 bits 0..3, port1 bit6
  assign irq_pin = {s_q.pin_s[lane(P1_LSB, 6)], s_q.pin_s[P3_LSB +: P3_W],
    s_q.pin_s[lane(P12_LSB, 0)]};
  assign irq_en = {s_q.alt[lane(P1_LSB, 6)], s_q.alt[P3_LSB +: P3_W],
    s_q.alt[lane(P12_LSB, 0)]};

  for (genvar g = 0; g < NUM_IRQ; g++) begin : g_irq
    ppfm_edge_det u_edge (
      .CLK(CLK),
      .RESETN(RESETN),
      .CE(CE),
      .ENABLE(irq_en[g]),
      .MODE(ppfm_edge_t'(s_q.edge_sel[2*g +: 2])),
      .LEVEL(irq_pin[g]),
      .REQ(EXT_IRQ[g])
    );
  end

  assign PAD = s_q.pad;
  assign PERIPH_IN = s_q.pin;
  assign PORT_IN = s_q.pin_s;
  assign DIR_STATE = s_q.dir;
  assign ALT_STATE = s_q.alt;
  // Board keeps this low outside programming; we only report it
  assign FLASH_PROG_REQ = s_q.flash;

  analog_reset_a: assert property (@(posedge CLK)
    $rose(RESETN) |-> ALT_STATE[P2_LSB +: P2_W] == P2_ANALOG_RST)
    else $error("Port 2 not analog after reset");
  no_drive_reset_a: assert property (@(posedge CLK)
    $rose(RESETN) |-> PAD.oe_n == DIR_RST && PAD.pull_en == PULL_RST)
    else $error("Pin drives after reset");
  od_high_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (PAD.oe_n[P6_LSB +: P6_W] != 2'h3) |-> PAD.out[P6_LSB +: P6_W] == 2'h0)
    else $error("Open-drain pin drives high");
  pull_cap_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (PAD.pull_en & ~PULL_CAP) == '0)
    else $error("Pull-up on a pin without option");
  dir_load_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && CFG_WE) |=> DIR_STATE == $past(CFG_DIR))
    else $error("Direction write lost");
  plain_ports_a: assert property (@(posedge CLK) disable iff (!RESETN)
    ALT_STATE[P4_LSB +: P4_W] == 2'h0 && ALT_STATE[P7_LSB +: P7_W] == 2'h0)
    else $error("Plain port in alternate mode");
  input_path_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE |=> PORT_IN == $past(PIN_IN))
    else $error("Pin sample missed");
  csu_out_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && ALT_STATE[lane(P1_LSB, 2)]) |=> PAD.out[lane(P1_LSB, 2)] ==
      $past(PERIPH_OUT.csu_data_out) && !PAD.oe_n[lane(P1_LSB, 2)])
    else $error("Serial data out not routed");

  // Peripheral outputs: one registered stage from mode and drive to the pad
  uart_a_tx_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && ALT_STATE[lane(P1_LSB, 0)] && !DIR_STATE[lane(P1_LSB, 0)]) |=>
      PAD.out[lane(P1_LSB, 0)] == $past(PERIPH_OUT.uart_a_transmit) &&
      !PAD.oe_n[lane(P1_LSB, 0)])
    else $error("Transmit A not routed");
  csu_clock_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && ALT_STATE[lane(P1_LSB, 0)] && DIR_STATE[lane(P1_LSB, 0)]) |=>
      PAD.out[lane(P1_LSB, 0)] == $past(PERIPH_OUT.csu_clock_out) &&
      PAD.oe_n[lane(P1_LSB, 0)] == !$past(PERIPH_OUT.csu_clock_oe))
    else $error("Serial clock drive not routed");
  uart_b_tx_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && ALT_STATE[lane(P1_LSB, 3)]) |=>
      PAD.out[lane(P1_LSB, 3)] == $past(PERIPH_OUT.uart_b_transmit) &&
      !PAD.oe_n[lane(P1_LSB, 3)])
    else $error("Transmit B not routed");
  timer_a_out_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && ALT_STATE[lane(P1_LSB, 5)]) |=>
      PAD.out[lane(P1_LSB, 5)] == $past(PERIPH_OUT.interval_timer_a_out) &&
      !PAD.oe_n[lane(P1_LSB, 5)])
    else $error("Interval timer A not routed");
  timer_b_out_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && ALT_STATE[lane(P1_LSB, 6)] && !DIR_STATE[lane(P1_LSB, 6)]) |=>
      PAD.out[lane(P1_LSB, 6)] == $past(PERIPH_OUT.interval_timer_b_out) &&
      !PAD.oe_n[lane(P1_LSB, 6)])
    else $error("Interval timer B not routed");
  counter_a_out_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && ALT_STATE[lane(P1_LSB, 7)] && !DIR_STATE[lane(P1_LSB, 7)]) |=>
      PAD.out[lane(P1_LSB, 7)] == $past(PERIPH_OUT.counter_a_out) &&
      !PAD.oe_n[lane(P1_LSB, 7)])
    else $error("Counter A output not routed");
  counter_b_out_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && ALT_STATE[lane(P3_LSB, 3)] && !DIR_STATE[lane(P3_LSB, 3)]) |=>
      PAD.out[lane(P3_LSB, 3)] == $past(PERIPH_OUT.counter_b_out) &&
      !PAD.oe_n[lane(P3_LSB, 3)])
    else $error("Counter B output not routed");
  twowire_data_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && ALT_STATE[lane(P6_LSB, 1)]) |=>
      PAD.oe_n[lane(P6_LSB, 1)] == !$past(PERIPH_OUT.twowire_data_low))
    else $error("Two-wire data sink not routed");
  twowire_clock_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && ALT_STATE[lane(P6_LSB, 0)]) |=>
      PAD.oe_n[lane(P6_LSB, 0)] == !$past(PERIPH_OUT.twowire_clock_low))
    else $error("Two-wire clock sink not routed");
  od_port_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && !ALT_STATE[lane(P6_LSB, 0)]) |=> PAD.oe_n[lane(P6_LSB, 0)] ==
      $past(DIR_STATE[lane(P6_LSB, 0)] | s_q.latch[lane(P6_LSB, 0)]))
    else $error("Open-drain port sink wrong");
  analog_lane_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && ALT_STATE[lane(P2_LSB, 0)]) |=> PAD.oe_n[lane(P2_LSB, 0)])
    else $error("Analog pin driven");
  analog_route_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE |=> PERIPH_IN.analog_sel == $past(ALT_STATE[P2_LSB +: P2_W]))
    else $error("Analog channel select wrong");

  // Peripheral inputs: one stage behind the port input sample
  csu_in_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE |=> PERIPH_IN.csu_clock_in == $past(PORT_IN[lane(P1_LSB, 0)]) &&
      PERIPH_IN.csu_data_in == $past(PORT_IN[lane(P1_LSB, 1)]))
    else $error("Serial inputs not routed");
  uart_rx_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE |=> PERIPH_IN.uart_a_receive == $past(PORT_IN[lane(P1_LSB, 1)]) &&
      PERIPH_IN.uart_b_receive == $past(PORT_IN[lane(P1_LSB, 4)]))
    else $error("Receive inputs not routed");
  counter_in_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE |=> PERIPH_IN.counter_a_clock_in == $past(PORT_IN[lane(P1_LSB, 7)]) &&
      PERIPH_IN.counter_b_clock_in == $past(PORT_IN[lane(P3_LSB, 3)]))
    else $error("Counter clocks not routed");
  twowire_in_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE |=> PERIPH_IN.twowire_clock_in == $past(PORT_IN[lane(P6_LSB, 0)]) &&
      PERIPH_IN.twowire_data_in == $past(PORT_IN[lane(P6_LSB, 1)]))
    else $error("Two-wire inputs not routed");
  clock_lvi_in_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE |=> PERIPH_IN.ext_lowvolt_detect_in == $past(PORT_IN[lane(P12_LSB, 0)]) &&
      PERIPH_IN.ext_main_clock_in == $past(PORT_IN[lane(P12_LSB, 2)]))
    else $error("Port 12 inputs not routed");
  debug_off_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE |=> DEBUG_VARIANT || PERIPH_IN.debug_in == 4'h0)
    else $error("Debug input on plain variant");
  alt_load_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (CE && CFG_WE) |=> ALT_STATE == $past(CFG_ALT & ALT_CAP))
    else $error("Alternate write lost");
  pull_gate_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE |=> PAD.pull_en == $past(s_q.pull & DIR_STATE))
    else $error("Pull-up not gated by direction");
  flash_follow_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE |=> FLASH_PROG_REQ == $past(FLASH_PROG_MODE_SELECT))
    else $error("Programming select not reported");
endmodule : ppfm_mux
`default_nettype wire

//--- ppfm_board.sv
// Board model for the port pins: pad drive, pull-ups, external drivers.
// Assumes the mux pad struct; oe_n low means the chip drives the pin.
`timescale 1ns/10ps
`default_nettype none
module ppfm_board
  import ppfm_pkg::*;
(
  input wire ppfm_pad_t PAD,
  input wire logic [PIN_W-1:0] EXT,
  output logic [PIN_W-1:0] PIN,
  output logic FLASH_SEL
);
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (!PAD.oe_n[i]) begin
        // Open-drain lanes can only sink, whatever the out bit says
        PIN[i] = OD_MASK[i] ? 1'b0 : PAD.out[i];
      end else begin
        PIN[i] = PAD.pull_en[i] | EXT[i];
      end
    end
  end
  // No programmer attached, so held low
  assign FLASH_SEL = 1'b0;
endmodule : ppfm_board
`default_nettype wire

//--- ppfm_mux_tb.sv
// Self-checking bench for the port pin function mux.
// Assumes ppfm_board on the pins; expectations queued with a due cycle.
`timescale 1ns/10ps
`default_nettype none
module ppfm_mux_tb
  import ppfm_pkg::*;
;
  typedef struct {
    int kind;
    int due;
    logic [PIN_W-1:0] exp;
    logic [PIN_W-1:0] mask;
  } ppfm_note_t;
  localparam logic [PIN_W-1:0] ALL = 27'h7ffffff;
  localparam logic [PIN_W-1:0] ALT_CAP = 27'h733fffc;
  localparam logic [PIN_W-1:0] PULL_OK = 27'h1cfc3ff;
  localparam int LANE [NUM_IRQ] = '{24, 14, 15, 16, 17, 8};
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic cfg_we;
  logic [PIN_W-1:0] cfg_dir, cfg_pull, cfg_alt, cfg_latch, ext;
  logic [2*NUM_IRQ-1:0] cfg_edge;
  ppfm_periph_out_t po;
  ppfm_pad_t pad;
  logic [PIN_W-1:0] pin_in, port_in, dir_st, alt_st;
  logic [NUM_IRQ-1:0] irq, irq_sel;
  logic flash_sel;
  ppfm_periph_in_t pin_per;
  logic flash_req;
  logic [31:0] seed = 32'h171c;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int irq_cnt = 0;
  ppfm_note_t q[$];

  always #(CLK_PERIOD_NS / 2.0) CLK = ~CLK;

  ppfm_mux #(.DEBUG_VARIANT(1'b0)) uut (.CLK(CLK), .RESETN(RESETN), .CE(1'b1),
    .CFG_WE(cfg_we), .CFG_DIR(cfg_dir), .CFG_PULL(cfg_pull), .CFG_ALT(cfg_alt),
    .CFG_LATCH(cfg_latch), .CFG_EDGE(cfg_edge), .FLASH_PROG_MODE_SELECT(flash_sel),
    .PIN_IN(pin_in), .PAD(pad), .PERIPH_OUT(po), .PERIPH_IN(pin_per), .EXT_IRQ(irq),
    .PORT_IN(port_in), .DIR_STATE(dir_st), .ALT_STATE(alt_st), .FLASH_PROG_REQ(flash_req));
  ppfm_board board (.PAD(pad), .EXT(ext), .PIN(pin_in), .FLASH_SEL(flash_sel));

  function automatic logic [PIN_W-1:0] r27();
    repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[PIN_W-1:0];
  endfunction : r27

  task automatic check(input logic [PIN_W-1:0] seen, input logic [PIN_W-1:0] want,
                       input int kind);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: kind %0d got %h expected %h", $time, kind, seen, want);
    end
  endtask : check

  task automatic note(input int kind, input int lat, input logic [PIN_W-1:0] e,
                      input logic [PIN_W-1:0] m);
    ppfm_note_t n;
    n = '{kind, cyc + lat, e, m};
    q.push_back(n);
  endtask : note

  task automatic finish_test();
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // Watcher: cyc moves only here, so drivers at posedge see it stable
  always @(negedge CLK) begin : watch
    logic [PIN_W-1:0] seen;
    int i;
    i = 0;
    irq_cnt += $countones(irq & irq_sel) + 16 * $countones(irq & ~irq_sel);
    while (i < q.size()) begin
      if (q[i].due <= cyc) begin
        case (q[i].kind)
          0: seen = dir_st;
          1: seen = alt_st;
          2: seen = pad.oe_n;
          3: seen = pad.out;
          4: seen = pad.pull_en;
          5: seen = port_in;
          7: seen = PIN_W'(pin_per);
          8: seen = PIN_W'(flash_req);
          default: begin
            seen = irq_cnt[PIN_W-1:0];
            irq_cnt = 0;
          end
        endcase
        check(seen & q[i].mask, q[i].exp & q[i].mask, q[i].kind);
        q.delete(i);
      end else begin
        i++;
      end
    end
    cyc++;
  end

  // Leaves the strobe high so back-to-back writes never double-assign it
  task automatic cfg(input logic [PIN_W-1:0] d, p, a, l, input logic [11:0] e);
    logic [PIN_W-1:0] ae;
    ae = a & ALT_CAP;
    cfg_dir <= d;
    cfg_pull <= p;
    cfg_alt <= a;
    cfg_latch <= l;
    cfg_edge <= e;
    cfg_we <= 1'b1;
    note(0, 1, d, ALL);
    note(1, 1, ae, ALL);
    note(2, 2, d | (l & OD_MASK), ~ae);
    note(3, 2, l, ~ae & ~OD_MASK);
    note(4, 2, p & PULL_OK & d, ~ae);
    @(posedge CLK);
  endtask : cfg

  initial begin
    logic [PIN_W-1:0] d, p, a, l, e, x, y;
    ppfm_periph_out_t pv;
    ppfm_periph_in_t pe;
    cfg_we = 1'b0;
    cfg_dir = ALL;
    cfg_pull = 27'h0;
    cfg_alt = 27'h0;
    cfg_latch = 27'h0;
    cfg_edge = 12'h0;
    ext = 27'h0;
    po = '0;
    irq_sel = 6'h0;
    repeat (12) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    note(0, 1, ALL, ALL);
    note(1, 1, 27'h0003c00, ALL);
    note(2, 1, ALL, ALL);
    note(4, 1, 27'h0, ALL);
    note(8, 1, 27'h0, ALL);
    repeat (3) @(posedge CLK);
    for (int k = 0; k < 24; k++) begin
      d = r27();
      p = r27();
      a = r27();
      l = r27();
      e = r27();
      po <= ppfm_periph_out_t'(e[10:0]);
      cfg(d, p, a, l, e[11:0]);
    end
    // Peripheral drive replaces the latch on lanes with alternate outputs; lanes 2, 8, 9 and 17 still heed direction
    e = r27();
    pv = ppfm_periph_out_t'(e[10:0]);
    po <= pv;
    a = 27'h03203b4;
    cfg(27'h0, 27'h0, a, 27'h0, 12'h0);
    cfg_we <= 1'b0;
    x = 27'h0;
    x[2] = pv.uart_a_transmit;
    x[4] = pv.csu_data_out;
    x[5] = pv.uart_b_transmit;
    x[7] = pv.interval_timer_a_out;
    x[8] = pv.interval_timer_b_out;
    x[9] = pv.counter_a_out;
    x[17] = pv.counter_b_out;
    y = 27'h0;
    y[20] = ~pv.twowire_clock_low;
    y[21] = ~pv.twowire_data_low;
    note(3, 1, x, a & ~OD_MASK);
    note(2, 1, y, a);
    // Drive must stand until the pad register has taken it
    @(posedge CLK);
    po <= '0;
    cfg(ALL, 27'h0, ALT_CAP, 27'h0, 12'h0);
    cfg_we <= 1'b0;
    repeat (3) @(posedge CLK);
    // Lanes 4, 5 and 7, whose alternate outputs drive whatever the direction, are left out
    for (int k = 0; k < 16; k++) begin
      x = r27();
      ext <= x;
      note(5, 1, x, 27'h7ffff4f);
      pe = '0;
      pe.csu_clock_in = x[2];
      pe.csu_data_in = x[3];
      pe.uart_a_receive = x[3];
      pe.uart_b_receive = x[6];
      pe.counter_a_clock_in = x[9];
      pe.counter_b_clock_in = x[17];
      pe.twowire_clock_in = x[20];
      pe.twowire_data_in = x[21];
      pe.ext_lowvolt_detect_in = x[24];
      pe.ext_main_clock_in = x[26];
      pe.analog_sel = 4'hf;
      note(7, 2, PIN_W'(pe), ALL);
      @(posedge CLK);
    end
    for (int m = 0; m < 4; m++) begin
      ext <= 27'h0;
      cfg(ALL, 27'h0, ALT_CAP, 27'h0, {6{m[1:0]}});
      cfg_we <= 1'b0;
      repeat (6) @(posedge CLK);
      for (int i = 0; i < NUM_IRQ; i++) begin
        irq_sel <= 6'h1 << i;
        note(6, 0, 27'h0, 27'h0);
        @(posedge CLK);
        ext[LANE[i]] <= 1'b1;
        repeat (5) @(posedge CLK);
        ext[LANE[i]] <= 1'b0;
        repeat (6) @(posedge CLK);
        note(6, 0, PIN_W'(m == 3 ? 2 : (m == 0 ? 0 : 1)), ALL);
      end
    end
    for (int w = 0; w < 40 && q.size() > 0; w++) @(posedge CLK);
    if (q.size() > 0) fails++;
    finish_test();
  end
endmodule : ppfm_mux_tb
`default_nettype wire
